// ### testbench/fp_ceil_checker.sv
// Port-level checks for the ceiling-convert and control-read block
`timescale 1ns/1ps
module fp_ceil_checker
  import fp_ceil_pkg::*;
#(
  parameter logic [31:0] IMPL_ID = 32'h0001_0000 // Arbitrary identification value
)(
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, low
  input wire logic op_valid, // Issue
  input wire op_kind_t op_kind, // Kind
  input wire logic [4:0] fmt, // Format
  input wire logic [4:0] source_float_select, // Selector
  input wire logic [4:0] dest_float_select, // Float dest
  input wire logic [4:0] target_gpr_select, // Gpr dest
  input wire logic cop1_usable, // Float unit on
  input wire logic cop2_usable, // Cop2 on
  input wire logic done, // Retired
  input wire logic float_wr_en, // Float write
  input wire logic [4:0] float_wr_select, // Float index
  input wire logic [63:0] float_wr_data, // Float data
  input wire logic gpr_wr_en, // Gpr write
  input wire logic [4:0] gpr_wr_select, // Gpr index
  input wire logic [31:0] gpr_wr_data, // Gpr data
  input wire logic exc_float, // Float trap
  input wire logic exc_unusable, // Unusable
  input wire logic exc_reserved // Reserved
);
  // ==========
  // Decoded issue conditions
  wire logic conv = op_valid && cop1_usable && op_kind inside {OP_CEIL_LONG, OP_CEIL_WORD};
  wire logic fmt_ok = fmt == FMT_SINGLE || fmt == FMT_DOUBLE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ==========
  // Results two edges after issue
  AST_UNUSABLE: assert property (op_valid && !cop1_usable && op_kind != OP_COP2_CTRL_READ
    |-> ##2 exc_unusable && !float_wr_en && !gpr_wr_en) else $error("unusable float unit not refused");
  AST_COP2_UNUSABLE: assert property (op_valid && op_kind == OP_COP2_CTRL_READ && !cop2_usable
    |-> ##2 exc_unusable && !gpr_wr_en) else $error("unusable cop2 not refused");
  AST_RESERVED: assert property (conv && !fmt_ok |-> ##2 exc_reserved && !float_wr_en)
    else $error("bad format not reserved");
  AST_IMPL_ID: assert property (op_valid && cop1_usable && op_kind == OP_FLOAT_CTRL_READ
    && source_float_select == SEL_IMPL_ID |-> ##2 gpr_wr_en && gpr_wr_data == IMPL_ID)
    else $error("selector 0 wrong");
  AST_GPR_SEL: assert property (gpr_wr_en |-> $past(op_valid, 2)
    && gpr_wr_select == $past(target_gpr_select, 2)) else $error("gpr index wrong");
  AST_DEST: assert property (float_wr_en |-> $past(conv, 2)
    && float_wr_select == $past(dest_float_select, 2)) else $error("float index wrong");
  AST_WORD_HIGH: assert property (float_wr_en && $past(op_kind, 2) == OP_CEIL_WORD
    |-> float_wr_data[63:32] == 32'h0000_0000) else $error("word result high half set");
  AST_TRAP: assert property (exc_float |-> !float_wr_en && done && $past(conv && fmt_ok, 2))
    else $error("trap with write");
  AST_ONE_RESULT: assert property (done |-> $onehot({float_wr_en, gpr_wr_en, exc_float, exc_unusable,
    exc_reserved})) else $error("done without single outcome");

  C_TRAP: cover property (exc_float);
  C_CONV: cover property (conv && fmt_ok ##2 float_wr_en);
  C_COP2: cover property (gpr_wr_en && $past(op_kind, 2) == OP_COP2_CTRL_READ);
endmodule : fp_ceil_checker

bind fp_ceil_convert_ctrl_read fp_ceil_checker #(.IMPL_ID(IMPL_ID)) u_fp_ceil_checker (.clk, .arst_n,
  .op_valid, .op_kind, .fmt, .source_float_select, .dest_float_select, .target_gpr_select, .cop1_usable,
  .cop2_usable, .done, .float_wr_en, .float_wr_select, .float_wr_data, .gpr_wr_en, .gpr_wr_select,
  .gpr_wr_data, .exc_float, .exc_unusable, .exc_reserved);

// ### testbench/issue_model.sv
// Model of the integer pipeline that issues operations to the datapath
`timescale 1ns/1ps
module issue_model
  import fp_ceil_pkg::*;
(
  input wire logic clk, // Clock
  output logic op_valid, // Issue
  output op_kind_t op_kind, // Kind
  output logic [4:0] fmt, // Format
  output logic [63:0] source_value, // Operand
  output logic [4:0] source_float_select, // Selector
  output logic [4:0] dest_float_select, // Float dest
  output logic [4:0] target_gpr_select, // Gpr dest
  output logic [15:0] cop2_select // Cop2 select
);
  // ==========
  // Quiet values from time zero
  initial
  begin
    op_valid = 1'b0;
    op_kind = OP_CEIL_LONG;
    fmt = FMT_DOUBLE;
    source_value = '0;
    source_float_select = 5'h00;
    dest_float_select = 5'h00;
    target_gpr_select = 5'h00;
    cop2_select = 16'h0000;
  end

  // One-cycle issue; no sixteen-register mode exists here, so long conversions are legal
  task issue(input op_kind_t k, input logic [4:0] f, input logic [63:0] v, input logic [4:0] s,
    input logic [15:0] c);
    @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    fmt <= f;
    source_value <= v;
    source_float_select <= s;
    dest_float_select <= ~s;
    target_gpr_select <= s ^ 5'h0a;
    cop2_select <= c;
    @(posedge clk);
    // Released operand and cop2 select show the inverse so a stale operand is never mistaken for live
    op_valid <= 1'b0;
    source_value <= ~v;
    cop2_select <= ~c;
  endtask : issue
endmodule : issue_model

// ### testbench/test_fp_ceil_convert_ctrl_read.sv
// Self-checking bench for the ceiling-convert and control-read block
`timescale 1ns/1ps
module test_fp_ceil_convert_ctrl_read;
  import fp_ceil_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0000_5a5a; // Arbitrary identification value
  localparam logic [31:0] PAT = 32'hfedc_ba98;
  logic clk, arst_n, ce, cop1_usable, cop2_usable, bus_wr, bus_rd, op_valid, done, irq;
  logic float_wr_en, gpr_wr_en, exc_float, exc_unusable, exc_reserved;
  op_kind_t op_kind;
  logic [4:0] fmt, source_float_select, dest_float_select, target_gpr_select, float_wr_select, gpr_wr_select, seen;
  logic [63:0] source_value, float_wr_data, fval;
  logic [15:0] cop2_select;
  logic [31:0] gpr_wr_data, bus_wdata, bus_rdata, rd, gval;
  logic [11:0] bus_addr;
  int n_fail, total_checks;

  fp_ceil_convert_ctrl_read #(.IMPL_ID(ID_VAL)) u_fp_ceil_convert_ctrl_read (.clk, .arst_n, .ce, .op_valid,
    .op_kind, .fmt, .source_value, .source_float_select, .dest_float_select, .target_gpr_select, .cop2_select,
    .cop1_usable, .cop2_usable, .done, .float_wr_en, .float_wr_select, .float_wr_data, .gpr_wr_en,
    .gpr_wr_select, .gpr_wr_data, .exc_float, .exc_unusable, .exc_reserved, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .irq);
  issue_model u_issue_model (.clk, .op_valid, .op_kind, .fmt, .source_value, .source_float_select,
    .dest_float_select, .target_gpr_select, .cop2_select);

  // ==========
  // Clock and shared tasks
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task conclude();
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task check(input string nm, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the read edge
  task rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd_reg

  // Issue one operation and capture its outcome, bounded wait on done
  task op(input op_kind_t k, input logic [4:0] f, input logic [63:0] v, input logic [4:0] s, input logic [15:0] c);
    int i;
    u_issue_model.issue(k, f, v, s, c);
    for (i = 0; i < 6 && done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1)
    begin
      n_fail++;
      conclude();
    end
    seen = {exc_float, exc_unusable, exc_reserved, float_wr_en, gpr_wr_en};
    fval = float_wr_data;
    gval = gpr_wr_data;
  endtask : op

  task conv(input op_kind_t k, input logic [4:0] f, input logic [63:0] v, input logic [63:0] e);
    op(k, f, v, 5'h03, 16'h0000);
    check("conv_outcome", seen, 5'b00010);
    check("conv_value", fval, e);
  endtask : conv

  task ctrl(input logic [4:0] s, input logic [31:0] e);
    op(OP_FLOAT_CTRL_READ, 5'h00, '0, s, 16'h0000);
    check("ctrl_outcome", seen, 5'b00001);
    check("ctrl_value", gval, e);
  endtask : ctrl

  // ==========
  // Scenarios
  task t_convert();
    conv(OP_CEIL_LONG, FMT_DOUBLE, 64'h3ff8_0000_0000_0000, 64'h0000_0000_0000_0002);
    conv(OP_CEIL_WORD, FMT_DOUBLE, 64'hbff8_0000_0000_0000, 64'h0000_0000_ffff_ffff);
    conv(OP_CEIL_WORD, FMT_SINGLE, 64'h0000_0000_4010_0000, 64'h0000_0000_0000_0003);
    conv(OP_CEIL_LONG, FMT_SINGLE, 64'h0000_0000_bf00_0000, 64'h0000_0000_0000_0000);
    conv(OP_CEIL_LONG, FMT_DOUBLE, 64'hc3e0_0000_0000_0000, 64'h8000_0000_0000_0000);
    conv(OP_CEIL_LONG, FMT_DOUBLE, 64'h41e0_0000_0000_0000, 64'h0000_0000_8000_0000);
    conv(OP_CEIL_WORD, FMT_DOUBLE, 64'h41e0_0000_0000_0000, 64'h0000_0000_7fff_ffff);
    conv(OP_CEIL_LONG, FMT_DOUBLE, 64'h43e0_0000_0000_0000, 64'h7fff_ffff_ffff_ffff);
    conv(OP_CEIL_WORD, FMT_SINGLE, 64'h0000_0000_7fc0_0000, 64'h0000_0000_7fff_ffff);
    conv(OP_CEIL_LONG, FMT_DOUBLE, 64'h7ff0_0000_0000_0000, 64'h7fff_ffff_ffff_ffff);
  endtask : t_convert

  task t_status_irq();
    rd_reg(OFS_STATUS, rd);
    check("status", rd, 32'h0001_0044);
    rd_reg(OFS_IRQ_STATUS, rd);
    check("irq_status", rd, 32'h0000_0005);
    check("irq_masked", irq, 1'b0);
    wr_reg(OFS_IRQ_MASK, 32'h0000_0006);
    check("irq_on", irq, 1'b1);
    wr_reg(OFS_IRQ_STATUS, 32'h0000_0005);
    check("irq_cleared", irq, 1'b0);
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    wr_reg(OFS_IRQ_MASK, 32'h0000_001f);
    ce <= 1'b1;
    rd_reg(OFS_IRQ_MASK, rd);
    check("ce_freeze", rd, 32'h0000_0006);
  endtask : t_status_irq

  // Invalid enabled: invalid traps, inexact alone still writes
  task t_trap();
    wr_reg(OFS_STATUS, 32'h0000_0800);
    op(OP_CEIL_LONG, FMT_DOUBLE, 64'h7ff0_0000_0000_0000, 5'h04, 16'h0000);
    check("trap", seen, 5'b10000);
    op(OP_CEIL_LONG, FMT_DOUBLE, 64'h3ff8_0000_0000_0000, 5'h05, 16'h0000);
    check("no_trap", seen, 5'b00010);
    check("irq_trap", irq, 1'b1);
    rd_reg(OFS_IRQ_STATUS, rd);
    check("irq_status_trap", rd, 32'h0000_0007);
    rd_reg(OFS_STATUS, rd);
    check("status_trap", rd, 32'h0000_1844);
    // Inexact enabled alone must also trap and drop the write
    wr_reg(OFS_STATUS, 32'h0000_0080);
    op(OP_CEIL_WORD, FMT_SINGLE, 64'h0000_0000_4010_0000, 5'h06, 16'h0000);
    check("inexact_trap", seen, 5'b10000);
  endtask : t_trap

  task t_ctrl_read();
    wr_reg(OFS_STATUS, PAT);
    ctrl(SEL_IMPL_ID, ID_VAL);
    ctrl(SEL_STATUS, PAT);
    ctrl(SEL_COND, {24'h00_0000, PAT[31:25], PAT[23]});
    ctrl(SEL_EXC, {14'h0000, PAT[17:12], 5'h00, PAT[6:2], 2'h0});
    ctrl(SEL_ENA, {20'h0_0000, PAT[11:7], 4'h0, PAT[24], PAT[1:0]});
    ctrl(5'h05, 32'h0000_0000);
  endtask : t_ctrl_read

  task t_cop2();
    wr_reg(OFS_COP2_BASE + 12'h008, 32'hc0de_0002);
    wr_reg(OFS_COP2_BASE + 12'h01c, 32'hc0de_0007);
    rd_reg(OFS_COP2_BASE + 12'h01c, rd);
    check("cop2_bus_read", rd, 32'hc0de_0007);
    op(OP_COP2_CTRL_READ, 5'h00, '0, 5'h06, 16'h0002);
    check("cop2_read", {seen, gval}, {5'b00001, 32'hc0de_0002});
    op(OP_COP2_CTRL_READ, 5'h00, '0, 5'h07, 16'h000f);
    check("cop2_alias", {seen, gval}, {5'b00001, 32'hc0de_0007});
    cop2_usable <= 1'b0;
    op(OP_COP2_CTRL_READ, 5'h00, '0, 5'h07, 16'h0002);
    check("cop2_unusable", seen, 5'b01000);
    cop2_usable <= 1'b1;
    rd_reg(12'h0f0, rd);
    check("unmapped", rd, 32'h0000_0000);
    wr_reg(OFS_IMPL_ID, 32'hffff_ffff);
    rd_reg(OFS_IMPL_ID, rd);
    check("id_read_only", rd, ID_VAL);
  endtask : t_cop2

  task t_refuse();
    cop1_usable <= 1'b0;
    op(OP_CEIL_WORD, FMT_SINGLE, '0, 5'h01, 16'h0000);
    check("unusable_conv", seen, 5'b01000);
    op(OP_FLOAT_CTRL_READ, 5'h00, '0, SEL_STATUS, 16'h0000);
    check("unusable_ctrl", seen, 5'b01000);
    cop1_usable <= 1'b1;
    op(OP_CEIL_LONG, 5'h14, '0, 5'h01, 16'h0000);
    check("reserved", seen, 5'b00100);
  endtask : t_refuse

  // ==========
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    cop1_usable = 1'b1;
    cop2_usable = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 12'h000;
    bus_wdata = 32'h0000_0000;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_convert();
    t_status_irq();
    t_trap();
    t_ctrl_read();
    t_cop2();
    t_refuse();
    conclude();
  end
endmodule : test_fp_ceil_convert_ctrl_read

// ### verilog/cop2_ctrl_mem.sv
// Small register array holding the coprocessor-2 control words
`timescale 1ns/1ps
module cop2_ctrl_mem
  import fp_ceil_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32,
  parameter int AW = 3
)(
  input wire logic clk, // Core clock
  input wire logic arst_n, // Asynchronous reset, low
  input wire logic ce, // Clock enable
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write index
  input wire logic [WIDTH-1:0] wr_data, // Write word
  input wire logic [AW-1:0] rd_a_addr, // Datapath read index
  output logic [WIDTH-1:0] rd_a_data, // Datapath read word
  input wire logic [AW-1:0] rd_b_addr, // Bus read index
  output logic [WIDTH-1:0] rd_b_data // Bus read word
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Storage; cleared at reset so reads are defined
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else if (ce && wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered read ports, both sample every enabled cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end
    else if (ce)
    begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule : cop2_ctrl_mem

// ### verilog/fp_ceil_convert_ctrl_read.sv
// Ceiling conversions, float and coprocessor-2 control reads, with register bus
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fp_ceil_convert_ctrl_read
  import fp_ceil_pkg::*;
#(
  parameter logic [31:0] IMPL_ID = 32'h0001_0000, // Arbitrary identification value
  parameter int COP2_DEPTH = 8,
  parameter int COP2_AW = 3,
  parameter bit COP2_PRESENT = 1'b1
)(
  input wire logic clk, // Core clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic op_valid, // Issue strobe
  input wire op_kind_t op_kind, // Operation kind
  input wire logic [4:0] fmt, // Source format field
  input wire logic [63:0] source_value, // Contents of the source float register
  input wire logic [4:0] source_float_select, // Source register or control selector
  input wire logic [4:0] dest_float_select, // Destination float register
  input wire logic [4:0] target_gpr_select, // Destination general register
  input wire logic [15:0] cop2_select, // Coprocessor-2 control select
  input wire logic cop1_usable, // Float unit enabled
  input wire logic cop2_usable, // Coprocessor 2 enabled
  output logic done, // Operation retired
  output logic float_wr_en, // Float register write
  output logic [4:0] float_wr_select, // Float register index
  output logic [63:0] float_wr_data, // Float register data
  output logic gpr_wr_en, // General register write
  output logic [4:0] gpr_wr_select, // General register index
  output logic [31:0] gpr_wr_data, // General register data
  output logic exc_float, // Enabled float exception taken
  output logic exc_unusable, // Coprocessor unusable
  output logic exc_reserved, // Reserved instruction
  input wire logic [BUS_AW-1:0] bus_addr, // Register bus address
  input wire logic [31:0] bus_wdata, // Register bus write data
  input wire logic bus_wr, // Register bus write strobe
  input wire logic bus_rd, // Register bus read strobe
  output logic [31:0] bus_rdata, // Register bus read data
  output logic irq // Interrupt, level
);

  // ==========================================================
  // Ceiling conversion of a single or double value
  function automatic conv_t ceil_convert(input logic [63:0] v, input logic single, input logic long_t);
    logic sign;
    logic nan_inf;
    logic zero;
    logic [52:0] mant;
    int e;
    logic [117:0] sh;
    logic [65:0] mag;
    logic [65:0] limit;
    logic frac_nz;
    logic big;
    logic over;
    conv_t r;
    sh = '0;
    mag = '0;
    frac_nz = 1'b0;
    big = 1'b0;
    if (single)
    begin
      sign = v[31];
      nan_inf = (v[30:23] == SGL_EXP_ONES);
      zero = (v[30:0] == '0);
      mant = {(v[30:23] != '0), v[22:0], 29'b0};
      e = (v[30:23] == '0) ? SGL_EMIN : int'(v[30:23]) - SGL_BIAS;
    end
    else
    begin
      sign = v[63];
      nan_inf = (v[62:52] == DBL_EXP_ONES);
      zero = (v[62:0] == '0);
      mant = {(v[62:52] != '0), v[51:0]};
      e = (v[62:52] == '0) ? DBL_EMIN : int'(v[62:52]) - DBL_BIAS;
    end
    if (e < 0)
      frac_nz = !zero;
    else if (e > MAX_SHIFT)
      big = 1'b1;
    else
    begin
      sh = {65'b0, mant} << e;
      mag = sh[117:FRAC_W];
      frac_nz = |sh[FRAC_W-1:0];
    end
    // Round toward plus infinity: only positive values with a fraction step up
    if (!sign && frac_nz)
      mag = 66'(mag + 66'h1);
    limit = long_t ? LIMIT_LONG : LIMIT_WORD;
    over = big || (sign ? (mag > limit) : (mag >= limit));
    r.invalid = nan_inf || over;
    r.inexact = frac_nz && !r.invalid;
    if (r.invalid)
      r.value = long_t ? MAX_LONG : MAX_WORD;
    else if (long_t)
      r.value = sign ? 64'(~mag + 66'h1) : mag[63:0];
    else
      r.value = {32'h0000_0000, sign ? 32'(~mag + 66'h1) : mag[31:0]};
    return r;
  endfunction : ceil_convert

  // Control register views built from the status word and the identification value
  function automatic logic [31:0] ctrl_view(input logic [4:0] sel, input logic [31:0] cs);
    logic [31:0] w;
    w = '0; // Unknown selectors read as zero, callers must not rely on it
    unique case (sel)
      SEL_IMPL_ID: w = IMPL_ID;
      SEL_COND: w = {24'h00_0000, cs[31:25], cs[CS_FCC0]};
      SEL_EXC: w = cs & EXC_MASK;
      SEL_ENA: w = {20'h0_0000, cs[11:7], 4'h0, cs[CS_FS], cs[CS_RM_HI:0]};
      SEL_STATUS: w = cs;
      default: w = '0;
    endcase
    return w;
  endfunction : ctrl_view

  // ==========================================================
  // Issue decode: exceptions checked before any work
  logic fmt_ok;
  logic is_conv;
  logic issue_unusable;
  logic issue_reserved;
  conv_t issue_conv;

  assign is_conv = (op_kind == OP_CEIL_LONG) || (op_kind == OP_CEIL_WORD);
  assign fmt_ok = (fmt == FMT_SINGLE) || (fmt == FMT_DOUBLE);
  // Unusable outranks reserved, as the coprocessor is checked first
  assign issue_unusable = (op_kind == OP_COP2_CTRL_READ) ? !cop2_usable : !cop1_usable;
  assign issue_reserved = !issue_unusable &&
                          ((is_conv && !fmt_ok) || (op_kind == OP_COP2_CTRL_READ && !COP2_PRESENT));
  assign issue_conv = ceil_convert(source_value, fmt == FMT_SINGLE, op_kind == OP_CEIL_LONG);

  // ==========================================================
  // Stage A registers
  logic a_valid;
  op_kind_t a_kind;
  logic [4:0] a_ctrl_sel;
  logic [4:0] a_fpr_sel;
  logic [4:0] a_gpr_sel;
  logic a_unusable;
  logic a_reserved;
  conv_t a_conv;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a_valid <= 1'b0;
      a_kind <= OP_CEIL_LONG;
      a_ctrl_sel <= '0;
      a_fpr_sel <= '0;
      a_gpr_sel <= '0;
      a_unusable <= 1'b0;
      a_reserved <= 1'b0;
      a_conv <= '0;
    end
    else if (ce)
    begin
      a_valid <= op_valid;
      a_kind <= op_kind;
      a_ctrl_sel <= source_float_select;
      a_fpr_sel <= dest_float_select;
      a_gpr_sel <= target_gpr_select;
      a_unusable <= op_valid && issue_unusable;
      a_reserved <= op_valid && issue_reserved;
      a_conv <= issue_conv;
    end
  end

  // ==========================================================
  // Coprocessor-2 control words
  logic [31:0] cop2_word;
  logic [31:0] cop2_bus_word;
  logic cop2_bus_hit;
  logic [31:0] status;

  assign cop2_bus_hit = (bus_addr >= OFS_COP2_BASE) &&
                        (bus_addr < 12'(OFS_COP2_BASE + 12'(COP2_DEPTH * 4)));

  cop2_ctrl_mem #(.DEPTH(COP2_DEPTH), .WIDTH(32), .AW(COP2_AW)) u_cop2 (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .wr_en(bus_wr && cop2_bus_hit),
    .wr_addr(bus_addr[COP2_AW+1:2]),
    .wr_data(bus_wdata),
    .rd_a_addr(cop2_select[COP2_AW-1:0]),
    .rd_a_data(cop2_word),
    .rd_b_addr(bus_addr[COP2_AW+1:2]),
    .rd_b_data(cop2_bus_word)
  );

  // ==========================================================
  // Stage A evaluation: cause bits, trap decision, result word
  logic conv_ok;
  logic [5:0] cause;
  logic trap;
  logic [31:0] ctrl_word;

  assign conv_ok = a_valid && !a_unusable && !a_reserved &&
                   (a_kind == OP_CEIL_LONG || a_kind == OP_CEIL_WORD);
  // Only invalid and inexact can arise here; overflow is reported as invalid
  assign cause = conv_ok ? (6'(a_conv.invalid) << EXC_INVALID) | (6'(a_conv.inexact) << EXC_INEXACT) : '0;
  assign trap = |(cause[4:0] & status[CS_ENA_LO +: 5]);
  assign ctrl_word = (a_kind == OP_COP2_CTRL_READ) ? cop2_word : ctrl_view(a_ctrl_sel, status);

  // ==========================================================
  // Control/status word: bus writes, hardware cause and sticky flags
  logic [31:0] next_status;

  always_comb
  begin
    next_status = (bus_wr && bus_addr == OFS_STATUS) ? bus_wdata : status;
    if (conv_ok)
    begin
      // Hardware wins over a same-cycle bus write for causes and flags
      next_status = (next_status & ~CS_CAUSE_MASK) | (32'(cause) << CS_CAUSE_LO);
      next_status = next_status | (32'(cause[4:0]) << CS_FLAG_LO);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status <= CS_RESET;
    else if (ce)
      status <= next_status;
  end

  // ==========================================================
  // Stage B: registered results and exceptions
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done <= 1'b0;
      float_wr_en <= 1'b0;
      float_wr_select <= '0;
      float_wr_data <= '0;
      gpr_wr_en <= 1'b0;
      gpr_wr_select <= '0;
      gpr_wr_data <= '0;
      exc_float <= 1'b0;
      exc_unusable <= 1'b0;
      exc_reserved <= 1'b0;
    end
    else if (ce)
    begin
      done <= a_valid;
      float_wr_en <= conv_ok && !trap;
      float_wr_select <= a_fpr_sel;
      float_wr_data <= a_conv.value;
      gpr_wr_en <= a_valid && !a_unusable && !a_reserved && !conv_ok;
      gpr_wr_select <= a_gpr_sel;
      gpr_wr_data <= ctrl_word;
      exc_float <= conv_ok && trap;
      exc_unusable <= a_unusable;
      exc_reserved <= a_reserved;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear; a new event wins over the clear
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_events;

  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_DONE] = a_valid;
    irq_events[IRQ_TRAP] = conv_ok && trap;
    irq_events[IRQ_INVALID] = conv_ok && a_conv.invalid;
    irq_events[IRQ_UNUSABLE] = a_unusable;
    irq_events[IRQ_RESERVED] = a_reserved;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_status <= '0;
    else if (ce)
    begin
      if (bus_wr && bus_addr == OFS_IRQ_STATUS)
        irq_status <= (irq_status & ~bus_wdata[IRQ_W-1:0]) | irq_events;
      else
        irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask <= '0;
    else if (ce && bus_wr && bus_addr == OFS_IRQ_MASK)
      irq_mask <= bus_wdata[IRQ_W-1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // Bus read data: registered, one cycle after the strobe
  logic [31:0] reg_rdata;
  logic rd_cop2;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= '0;
      rd_cop2 <= 1'b0;
    end
    else if (ce)
    begin
      rd_cop2 <= bus_rd && cop2_bus_hit;
      if (!bus_rd)
        reg_rdata <= '0;
      else if (bus_addr == OFS_STATUS)
        reg_rdata <= status;
      else if (bus_addr == OFS_IRQ_STATUS)
        reg_rdata <= 32'(irq_status);
      else if (bus_addr == OFS_IRQ_MASK)
        reg_rdata <= 32'(irq_mask);
      else if (bus_addr == OFS_IMPL_ID)
        reg_rdata <= IMPL_ID;
      else
        reg_rdata <= '0; // Unmapped reads give zero
    end
  end

  // Memory word is already registered, so the mux only picks a flop
  assign bus_rdata = rd_cop2 ? cop2_bus_word : reg_rdata;

endmodule : fp_ceil_convert_ctrl_read

// ### verilog/fp_ceil_pkg.sv
// Constants, field positions and types for the ceiling-convert and control-read datapath
package fp_ceil_pkg;

  // ==========================================================
  // Operation kinds issued by the pipeline
  typedef enum logic [1:0] {OP_CEIL_LONG, OP_CEIL_WORD, OP_FLOAT_CTRL_READ, OP_COP2_CTRL_READ} op_kind_t;

  // ==========================================================
  // Source formats and float field layout
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam int SGL_BIAS = 127;
  localparam int DBL_BIAS = 1023;
  localparam int SGL_EMIN = -126;
  localparam int DBL_EMIN = -1022;
  localparam int FRAC_W = 52;
  localparam int MAX_SHIFT = 64;
  localparam logic [7:0] SGL_EXP_ONES = 8'hff;
  localparam logic [10:0] DBL_EXP_ONES = 11'h7ff;

  // Range limits as magnitudes and default results
  localparam logic [65:0] LIMIT_LONG = 66'h0_8000_0000_0000_0000;
  localparam logic [65:0] LIMIT_WORD = 66'h0_0000_0000_8000_0000;
  localparam logic [63:0] MAX_LONG = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] MAX_WORD = 64'h0000_0000_7fff_ffff;

  // ==========================================================
  // Control register selectors
  localparam logic [4:0] SEL_IMPL_ID = 5'h00;
  localparam logic [4:0] SEL_COND = 5'h19;
  localparam logic [4:0] SEL_EXC = 5'h1a;
  localparam logic [4:0] SEL_ENA = 5'h1c;
  localparam logic [4:0] SEL_STATUS = 5'h1f;

  // Control/status field positions
  localparam int CS_FLAG_LO = 2;
  localparam int CS_ENA_LO = 7;
  localparam int CS_CAUSE_LO = 12;
  localparam int CS_RM_HI = 1;
  localparam int CS_FS = 24;
  localparam int CS_FCC0 = 23;
  localparam int EXC_INEXACT = 0;
  localparam int EXC_OVERFLOW = 2;
  localparam int EXC_INVALID = 4;
  localparam int EXC_UNIMPL = 5;
  localparam logic [31:0] CS_CAUSE_MASK = 32'h0003_f000;
  localparam logic [31:0] CS_RESET = 32'h0000_0000;
  localparam logic [31:0] COND_MASK = 32'hfe80_0000;
  localparam logic [31:0] EXC_MASK = 32'h0003_f07c;
  localparam logic [31:0] ENA_MASK = 32'h0000_0f83;

  // ==========================================================
  // Register bus map
  localparam int BUS_AW = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFS_IMPL_ID = 12'h00c;
  localparam logic [11:0] OFS_COP2_BASE = 12'h100;
  localparam int IRQ_W = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRAP = 1;
  localparam int IRQ_INVALID = 2;
  localparam int IRQ_UNUSABLE = 3;
  localparam int IRQ_RESERVED = 4;

  // Conversion result bundle
  typedef struct packed {
    logic [63:0] value;
    logic invalid;
    logic inexact;
  } conv_t;

endpackage : fp_ceil_pkg
